// ===== swrs_regs.svh
/*
 * Constants of the switch reset sequencer: timing, field positions,
 * mode codes and reset values.
 * Assumes one 100 MHz core clock; included by package and modules.
 */
`ifndef SWRS_REGS_SVH
`define SWRS_REGS_SVH
// Operation
// - master bus released before EEPROM load
// - mode-selected EEPROM load updates registers
// - load error: abort, halt, record error
// - load done flag on finish or error
// - halted: all reset except buses, CSRs
// - halt held until agent clears bit
// - halted: agent reaches CSRs and EEPROM
// - normal operation within 1 s; load 200ms
// - EEPROM write side effects act immediately
// - warm reset completion before reset
// - downstream reset pins default to input
// - mode 0x1 selects EEPROM initialisation
// - three hot reset triggers
// - disable bit masks link-down trigger
// - downstream links forward hot reset
// - hot reset spares PLL, serdes, buses
// - hot reset clears non-sticky fields
// - training starts, quasi-reset follows at once
// - links train within 20ms
// - config retry within 100ms
// - boot inputs sampled on pin release
// - halt pin sets halt status bit
// - hot reset completion before reset

`define SWRS_CLK_KHZ       100000
`define SWRS_EEP_BUDGET_MS 200
`define SWRS_NORMAL_MS     1000
`define SWRS_LINK_TRAIN_MS 20
`define SWRS_CFG_READY_MS  100

`define SWRS_MODE_EEPROM   4'h1
`define SWRS_ERR_TIMEOUT   8'hFF

// reset-control vector positions and reset value
`define SWRS_RST_CORE      0
`define SWRS_RST_QUASI     1
`define SWRS_RST_SLAVE     2
`define SWRS_RST_MASTER    3
`define SWRS_RST_INIT      4'hF

// synchronised pin vector positions
`define SWRS_SYNC_W        7
`define SWRS_PIN_RSTN      0
`define SWRS_PIN_MODE_LO   1
`define SWRS_PIN_MODE_HI   4
`define SWRS_PIN_SLOW      5
`define SWRS_PIN_HALT      6

`define SWRS_DS_PORTS      2
`define SWRS_TMR_W         32
`endif

// ===== swrs_pkg.sv
/*
 * Types of the switch reset sequencer.
 * Assumes swrs_regs.svh for widths and reset values.
 */
`include "swrs_regs.svh"

package swrs_pkg;
    typedef enum logic [3:0] {
        ST_PERST  = 4'h0,
        ST_BOOT   = 4'h1,
        ST_SLAVE  = 4'h2,
        ST_MASTER = 4'h3,
        ST_LOAD   = 4'h4,
        ST_HALT   = 4'h5,
        ST_RUN    = 4'h6,
        ST_HOT    = 4'h7,
        ST_WARM   = 4'h8,
        ST_QUASI  = 4'h9
    } swrs_st_type;

    typedef struct packed {
        swrs_st_type                 st;
        logic [3:0]                  rst;
        logic [3:0]                  mode;
        logic                        slow;
        logic                        boot_halt;
        logic                        from_pin;
        logic                        nonsticky;
        logic                        train;
        logic                        load_start;
        logic                        csr_en;
        logic                        warm_cpl;
        logic                        hot_cpl;
        logic                        halt_ctl;
        logic                        halt_sts;
        logic                        done;
        logic                        err;
        logic [7:0]                  code;
        logic                        cfg_v;
        logic [11:0]                 cfg_a;
        logic [31:0]                 cfg_d;
        logic [`SWRS_DS_PORTS-1:0]   ds_tx;
        logic [`SWRS_DS_PORTS-1:0]   ds_o;
        logic [`SWRS_DS_PORTS-1:0]   ds_oe;
        logic                        dl_prev;
        logic                        normal;
    } swrs_seq_type;

    localparam swrs_seq_type SWRS_SEQ_INIT = '{st: ST_PERST, rst: `SWRS_RST_INIT, from_pin: 1'b1, default: '0};

    typedef struct packed {
        logic [`SWRS_SYNC_W-1:0] s1;
        logic [`SWRS_SYNC_W-1:0] s2;
    } swrs_sync_type;

    typedef struct packed {
        logic [`SWRS_TMR_W-1:0] cnt;
        logic                   run;
        logic                   expired;
    } swrs_tmr_type;
endpackage

// ===== swrs_sync.sv
/*
 * Two-flop synchroniser for the boot and reset pins.
 * Assumes pins are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`include "swrs_regs.svh"

module swrs_sync (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     sys_rst,
    // pins and synchronised copy
    input  wire logic [`SWRS_SYNC_W-1:0]  pin_in,
    output logic      [`SWRS_SYNC_W-1:0]  pin_sync
);
    import swrs_pkg::*;

    swrs_sync_type q;
    swrs_sync_type d;

    // first flop feeds only the second
    always_comb begin
        d.s1 = pin_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_sync = q.s2;
endmodule

// ===== swrs_timer.sv
/*
 * Budget timer: counts limit cycles after start, then flags expiry.
 * Assumes start and stop come from logic on core_clk.
 */
`timescale 1ns/1ps
`include "swrs_regs.svh"

module swrs_timer (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    // control
    input  wire logic                    start,
    input  wire logic                    stop,
    input  wire logic [`SWRS_TMR_W-1:0]  limit,
    // status
    output logic                         expired
);
    import swrs_pkg::*;

    swrs_tmr_type q;
    swrs_tmr_type d;

    always_comb begin
        d = q;
        if (start) begin
            d.cnt = limit;
            d.run = 1'b1;
            d.expired = 1'b0;
        end else if (stop) begin
            d.run = 1'b0;
        end else if (q.run) begin
            if (q.cnt <= `SWRS_TMR_W'(1)) begin
                d.run = 1'b0;
                d.expired = 1'b1;
            end else begin
                d.cnt = q.cnt - `SWRS_TMR_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.expired;
endmodule

// ===== swrs_seq.sv
/*
 * Switch reset sequencer: fundamental, warm and hot reset sequencing,
 * EEPROM load supervision and halt-after-reset.
 * Assumes CSR strobes, loader and link status share core_clk; boot
 * pins are asynchronous.
 */
`timescale 1ns/1ps
`include "swrs_regs.svh"

module swrs_seq #(
    parameter int unsigned EEP_BUDGET_CYC = `SWRS_EEP_BUDGET_MS * `SWRS_CLK_KHZ
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    // boot pins
    input  wire logic                       fundamental_reset_n,
    input  wire logic [3:0]                 operating_mode_select,
    input  wire logic                       master_bus_slow_select,
    input  wire logic                       halt_after_reset_pin,
    // control register strobes
    input  wire logic                       warm_reset_request,
    input  wire logic                       hot_reset_request,
    input  wire logic                       link_down_hot_reset_disable,
    input  wire logic                       halt_clear,
    // upstream link
    input  wire logic                       us_ts1_hot_reset,
    input  wire logic                       us_dl_down,
    // downstream ports
    input  wire logic [`SWRS_DS_PORTS-1:0]  ds_link_up,
    input  wire logic [`SWRS_DS_PORTS-1:0]  ds_reset_func_en,
    // eeprom loader
    input  wire logic                       eep_wr_valid,
    input  wire logic [11:0]                eep_wr_addr,
    input  wire logic [31:0]                eep_wr_data,
    input  wire logic                       eep_set_halt,
    input  wire logic                       eep_load_done,
    input  wire logic                       eep_load_error,
    input  wire logic [7:0]                 eep_error_code,
    // reset controls
    output logic                            core_rst,
    output logic                            nonsticky_rst,
    output logic                            stack_quasi_rst,
    output logic                            link_train_en,
    output logic                            slave_bus_rst,
    output logic                            master_bus_rst,
    output logic                            master_bus_slow,
    output logic                            csr_access_en,
    output logic                            normal_op,
    // completions
    output logic                            warm_reset_cpl,
    output logic                            hot_reset_cpl,
    // status bits
    output logic                            halt_after_reset,
    output logic                            halt_status,
    output logic                            load_done,
    output logic                            load_error,
    output logic [7:0]                      load_error_code,
    output logic                            eep_load_start,
    // register writes from eeprom
    output logic                            cfg_wr_valid,
    output logic [11:0]                     cfg_wr_addr,
    output logic [31:0]                     cfg_wr_data,
    // downstream reset pins
    output logic [`SWRS_DS_PORTS-1:0]       ds_hot_reset_tx,
    output logic [`SWRS_DS_PORTS-1:0]       ds_reset_o,
    output logic [`SWRS_DS_PORTS-1:0]       ds_reset_oe
);
    import swrs_pkg::*;

    swrs_seq_type              q;
    swrs_seq_type              d;
    logic [`SWRS_SYNC_W-1:0]   pins;
    logic                      tmr_expired;
    logic                      rstn;
    logic                      hot_trig;
    logic [`SWRS_DS_PORTS-1:0] tx_w;
    logic [`SWRS_DS_PORTS-1:0] oe_w;

    swrs_sync u_sync (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   ({halt_after_reset_pin, master_bus_slow_select,
                    operating_mode_select, fundamental_reset_n}),
        .pin_sync (pins)
    );

    swrs_timer u_timer (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .start    (q.load_start),
        .stop     (q.st != ST_LOAD),
        .limit    (`SWRS_TMR_W'(EEP_BUDGET_CYC)),
        .expired  (tmr_expired)
    );

    assign rstn = pins[`SWRS_PIN_RSTN];

    assign hot_trig = us_ts1_hot_reset | hot_reset_request
                    | (us_dl_down & ~q.dl_prev & ~link_down_hot_reset_disable);

    for (genvar i = 0; i < `SWRS_DS_PORTS; i++) begin : g_ds
        assign tx_w[i] = ds_link_up[i];
        // pins are inputs in fundamental reset
        assign oe_w[i] = ds_reset_func_en[i] & (q.st != ST_PERST) & (q.st != ST_WARM);
    end

    always_comb begin
        d = q;
        d.load_start = 1'b0;
        d.warm_cpl = 1'b0;
        d.hot_cpl = 1'b0;
        d.cfg_v = 1'b0;
        d.nonsticky = 1'b0;
        d.ds_tx = '0;
        d.dl_prev = us_dl_down;
        if (halt_clear) begin
            d.halt_ctl = 1'b0;
        end
        case (q.st)
            ST_PERST: begin
                d.rst = `SWRS_RST_INIT;
                d.train = 1'b0;
                d.csr_en = 1'b0;
                d.normal = 1'b0;
                d.from_pin = 1'b1;
                d.st = ST_BOOT;
            end
            ST_BOOT: begin
                if (q.from_pin) begin
                    d.mode = pins[`SWRS_PIN_MODE_HI:`SWRS_PIN_MODE_LO];
                    d.slow = pins[`SWRS_PIN_SLOW];
                    d.boot_halt = pins[`SWRS_PIN_HALT];
                end
                if (q.from_pin ? pins[`SWRS_PIN_HALT] : q.boot_halt) begin
                    d.halt_sts = 1'b1;
                end
                d.train = 1'b1;
                d.rst[`SWRS_RST_QUASI] = 1'b1;
                d.done = 1'b0;
                d.err = 1'b0;
                d.code = '0;
                d.from_pin = 1'b0;
                d.st = ST_SLAVE;
            end
            ST_SLAVE: begin
                d.rst[`SWRS_RST_SLAVE] = 1'b0;
                d.csr_en = 1'b1;
                d.st = ST_MASTER;
            end
            ST_MASTER: begin
                d.rst[`SWRS_RST_MASTER] = 1'b0;
                if (q.mode == `SWRS_MODE_EEPROM) begin
                    d.load_start = 1'b1;
                    d.st = ST_LOAD;
                end else begin
                    d.st = q.halt_ctl ? ST_HALT : ST_RUN;
                end
            end
            ST_LOAD: begin
                d.cfg_v = eep_wr_valid;
                d.cfg_a = eep_wr_addr;
                d.cfg_d = eep_wr_data;
                if (eep_set_halt) begin
                    d.halt_ctl = 1'b1;
                end
                if (eep_load_error || (tmr_expired && !q.load_start)) begin
                    d.err = 1'b1;
                    d.code = eep_load_error ? eep_error_code : `SWRS_ERR_TIMEOUT;
                    d.halt_ctl = 1'b1;
                    d.done = 1'b1;
                    d.st = ST_HALT;
                end else if (eep_load_done) begin
                    d.done = 1'b1;
                    d.st = (q.halt_ctl || eep_set_halt) ? ST_HALT : ST_RUN;
                end
            end
            ST_HALT: begin
                d.rst = `SWRS_RST_INIT;
                d.rst[`SWRS_RST_SLAVE] = 1'b0;
                d.rst[`SWRS_RST_MASTER] = 1'b0;
                d.csr_en = 1'b1;
                if (!q.halt_ctl) begin
                    d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                d.rst[`SWRS_RST_CORE] = 1'b0;
                d.rst[`SWRS_RST_QUASI] = 1'b0;
                d.normal = 1'b1;
                if (warm_reset_request) begin
                    d.warm_cpl = 1'b1;
                    d.st = ST_WARM;
                end else if (hot_trig) begin
                    d.hot_cpl = hot_reset_request;
                    d.st = ST_HOT;
                end
            end
            ST_WARM: begin
                d.rst = `SWRS_RST_INIT;
                d.train = 1'b0;
                d.csr_en = 1'b0;
                d.normal = 1'b0;
                d.st = ST_BOOT;
            end
            ST_HOT: begin
                d.rst[`SWRS_RST_CORE] = 1'b1;
                d.rst[`SWRS_RST_QUASI] = 1'b1;
                d.nonsticky = 1'b1;
                d.ds_tx = tx_w;
                d.train = 1'b0;
                d.normal = 1'b0;
                if (!us_ts1_hot_reset) begin
                    d.st = ST_QUASI;
                end
            end
            ST_QUASI: begin
                d.train = 1'b1;
                d.rst[`SWRS_RST_CORE] = 1'b0;
                d.st = ST_RUN;
            end
            default: begin
                d.st = ST_PERST;
            end
        endcase
        d.ds_oe = oe_w;
        d.ds_o = {`SWRS_DS_PORTS{~d.rst[`SWRS_RST_CORE]}};
        // pin reset overrides state, reset vector, normal flag and load start
        if (!rstn) begin
            d.st = ST_PERST;
            d.rst = `SWRS_RST_INIT;
            d.normal = 1'b0;
            // no load start while master bus held
            d.load_start = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= SWRS_SEQ_INIT;
        end else begin
            q <= d;
        end
    end

    assign core_rst        = q.rst[`SWRS_RST_CORE];
    assign stack_quasi_rst = q.rst[`SWRS_RST_QUASI];
    assign slave_bus_rst   = q.rst[`SWRS_RST_SLAVE];
    assign master_bus_rst  = q.rst[`SWRS_RST_MASTER];
    assign nonsticky_rst   = q.nonsticky;
    assign link_train_en   = q.train;
    assign master_bus_slow = q.slow;
    assign csr_access_en   = q.csr_en;
    assign normal_op       = q.normal;
    assign warm_reset_cpl  = q.warm_cpl;
    assign hot_reset_cpl   = q.hot_cpl;
    assign halt_after_reset = q.halt_ctl;
    assign halt_status     = q.halt_sts;
    assign load_done       = q.done;
    assign load_error      = q.err;
    assign load_error_code = q.code;
    assign eep_load_start  = q.load_start;
    assign cfg_wr_valid    = q.cfg_v;
    assign cfg_wr_addr     = q.cfg_a;
    assign cfg_wr_data     = q.cfg_d;
    assign ds_hot_reset_tx = q.ds_tx;
    assign ds_reset_o      = q.ds_o;
    assign ds_reset_oe     = q.ds_oe;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_master_before_load: assert property (q.load_start |-> !master_bus_rst && !slave_bus_rst)
        else $error("eeprom load started with a bus in reset");
    a_mode_load: assert property (
        q.st == ST_MASTER && q.mode == `SWRS_MODE_EEPROM && rstn |=> eep_load_start && q.st == ST_LOAD)
        else $error("eeprom mode did not start a load");
    a_load_fwd: assert property (
        q.st == ST_LOAD && eep_wr_valid |=> cfg_wr_valid && cfg_wr_addr == $past(eep_wr_addr))
        else $error("eeprom write not forwarded next cycle");
    a_err_halt: assert property (
        q.st == ST_LOAD && eep_load_error && rstn
        |=> halt_after_reset && load_error && load_error_code == $past(eep_error_code) && q.st == ST_HALT)
        else $error("load error did not halt");
    a_done_flag: assert property (
        q.st == ST_LOAD && (eep_load_done || eep_load_error) |=> load_done)
        else $error("load done flag not set");
    a_halt_hold: assert property (
        q.st == ST_HALT |-> core_rst && stack_quasi_rst && !slave_bus_rst && !master_bus_rst && csr_access_en)
        else $error("halted state resets wrong logic");
    a_halt_exit: assert property (
        q.st == ST_HALT && !halt_after_reset && rstn |=> q.st == ST_RUN ##1 normal_op && !core_rst)
        else $error("halt not left after clear");
    a_warm_cpl: assert property (
        q.st == ST_RUN && warm_reset_request && rstn |=> warm_reset_cpl && !core_rst ##1 core_rst)
        else $error("warm reset completion not first");
    a_hot_cpl: assert property (
        q.st == ST_RUN && hot_reset_request && !warm_reset_request && rstn
        |=> hot_reset_cpl && !core_rst ##1 core_rst && nonsticky_rst && !slave_bus_rst)
        else $error("hot reset completion not first");
    a_dl_gate: assert property (
        q.st == ST_RUN && link_down_hot_reset_disable && !us_ts1_hot_reset && !hot_reset_request
        && !warm_reset_request && rstn |=> q.st == ST_RUN)
        else $error("masked link down started hot reset");
    a_hot_fwd: assert property (q.st == ST_HOT |=> ds_hot_reset_tx == $past(ds_link_up))
        else $error("hot reset not forwarded downstream");
    a_gpio_input: assert property (q.st == ST_PERST |=> ds_reset_oe == '0)
        else $error("downstream reset pin driven in reset");
    a_quasi_train: assert property (q.st == ST_QUASI |=> link_train_en && stack_quasi_rst)
        else $error("quasi phase without training");
    a_halt_pin: assert property (q.st == ST_BOOT && q.from_pin && pins[`SWRS_PIN_HALT] |=> halt_status)
        else $error("halt pin not reported");

    c_load_ok: cover property (q.st == ST_LOAD ##1 q.st == ST_RUN);
    c_load_err: cover property (q.st == ST_LOAD ##1 q.st == ST_HALT);
    c_hot: cover property (q.st == ST_HOT ##1 q.st == ST_QUASI ##1 q.st == ST_RUN);
    c_warm: cover property (warm_reset_cpl ##1 q.st == ST_BOOT);
endmodule

// ===== swrs_loader_model.sv
/*
 * EEPROM loader stand-in: one register write, then done, error or silence.
 * Assumes start pulses from the sequencer on core_clk.
 */
`timescale 1ns/1ps

module swrs_loader_model (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // bench control: 0 ok, 1 error, 2 silent, 3 halt then ok
    input  wire logic [1:0]  fault,
    input  wire logic        start,
    // loader outputs
    output logic             wr_valid,
    output logic [11:0]      wr_addr,
    output logic [31:0]      wr_data,
    output logic             set_halt,
    output logic             done,
    output logic             error,
    output logic [7:0]       code
);
    logic [3:0] cnt_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            cnt_q <= 4'h0;
        else if (start)
            cnt_q <= 4'h1;
        else if (cnt_q != 4'h0 && cnt_q != 4'h6)
            cnt_q <= cnt_q + 4'h1;
    end

    // idle bus shows inverted data
    assign wr_valid = (cnt_q == 4'h3);
    assign wr_addr  = wr_valid ? 12'h010 : 12'hFEF;
    assign wr_data  = wr_valid ? 32'hA5A5_0001 : 32'h5A5A_FFFE;
    assign set_halt = (cnt_q == 4'h4) && (fault == 2'h3);
    assign done     = (cnt_q == 4'h5) && (fault == 2'h0 || fault == 2'h3);
    assign error    = (cnt_q == 4'h5) && (fault == 2'h1);
    assign code     = 8'h21;
endmodule

// ===== switch_reset_sequencer_tb.sv
/*
 * Testbench of the switch reset sequencer: boot, hot triggers, halt, timeout.
 * Assumes swrs_seq with a short load budget and the loader model.
 */
`timescale 1ns/1ps

module switch_reset_sequencer_tb;
    import swrs_pkg::*;
    logic core_clk = 0, sys_rst = 1, fundamental_reset_n = 0, master_bus_slow_select = 1;
    logic halt_after_reset_pin = 1, warm_reset_request = 0, hot_reset_request = 0, halt_clear = 0;
    logic link_down_hot_reset_disable = 0, us_ts1_hot_reset = 0, us_dl_down = 0;
    logic [3:0] operating_mode_select = 4'h1;
    logic [1:0] fault = 2'h0, ds_link_up = 2'h1, ds_reset_func_en = 2'h3;
    logic eep_wr_valid, eep_set_halt, eep_load_done, eep_load_error, core_rst, nonsticky_rst, stack_quasi_rst;
    logic link_train_en, slave_bus_rst, master_bus_rst, master_bus_slow, csr_access_en, normal_op;
    logic warm_reset_cpl, hot_reset_cpl, halt_after_reset, halt_status, load_done, load_error;
    logic eep_load_start, cfg_wr_valid, warm_ok = 0, mb_ok = 0, bus_hit = 0;
    logic [7:0] eep_error_code, load_error_code;
    logic [11:0] eep_wr_addr, cfg_wr_addr;
    logic [31:0] eep_wr_data, cfg_wr_data;
    logic [1:0] ds_hot_reset_tx, ds_reset_o, ds_reset_oe, tx_cap = 2'h0;
    logic [43:0] wr_cap = '0;
    logic [4:0] rows [4] = '{5'b10001, 5'b01001, 5'b01100, 5'b00011};
    int mismatches = 0, check_count = 0, nsr_n = 0, hcpl_n = 0, n0, c0, r;

    swrs_seq #(.EEP_BUDGET_CYC(50)) uut (
        .core_clk, .sys_rst, .fundamental_reset_n, .operating_mode_select, .master_bus_slow_select,
        .halt_after_reset_pin, .warm_reset_request, .hot_reset_request, .link_down_hot_reset_disable,
        .halt_clear, .us_ts1_hot_reset, .us_dl_down, .ds_link_up, .ds_reset_func_en, .eep_wr_valid,
        .eep_wr_addr, .eep_wr_data, .eep_set_halt, .eep_load_done, .eep_load_error,
        .eep_error_code, .core_rst, .nonsticky_rst, .stack_quasi_rst, .link_train_en, .slave_bus_rst,
        .master_bus_rst, .master_bus_slow, .csr_access_en, .normal_op, .warm_reset_cpl,
        .hot_reset_cpl, .halt_after_reset, .halt_status, .load_done, .load_error, .load_error_code,
        .eep_load_start, .cfg_wr_valid, .cfg_wr_addr, .cfg_wr_data, .ds_hot_reset_tx, .ds_reset_o,
        .ds_reset_oe);

    swrs_loader_model loader (
        .core_clk, .sys_rst, .fault, .start(eep_load_start), .wr_valid(eep_wr_valid),
        .wr_addr(eep_wr_addr), .wr_data(eep_wr_data), .set_halt(eep_set_halt), .done(eep_load_done),
        .error(eep_load_error), .code(eep_error_code));

    always #5 core_clk = ~core_clk;

    // pulse and ordering watch
    always @(posedge core_clk) begin
        if (nonsticky_rst === 1'b1) begin
            nsr_n++;
            tx_cap = ds_hot_reset_tx;
            if (master_bus_rst !== 1'b0 || slave_bus_rst !== 1'b0) bus_hit = 1'b1;
        end
        if (hot_reset_cpl === 1'b1) hcpl_n++;
        if (warm_reset_cpl === 1'b1) warm_ok = (core_rst === 1'b0);
        if (eep_load_start === 1'b1) mb_ok = (master_bus_rst === 1'b0);
        if (cfg_wr_valid === 1'b1) wr_cap = {cfg_wr_addr, cfg_wr_data};
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [43:0] exp, input logic [43:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic warm_boot(input int n);
        warm_reset_request = 1;
        tick(1);
        warm_reset_request = 0;
        tick(n);
    endtask

    task automatic wait_run(input int lim);
        for (int i = 0; i < lim && normal_op !== 1'b1; i++) tick(1);
        if (normal_op !== 1'b1) begin
            mismatches++;
            $display("Error normal_op expected 1 seen %b", normal_op);
            conclude();
        end
    endtask

    initial begin
        tick(16);
        chk("core_rst", 1, core_rst);
        chk("ds_reset_oe", 0, ds_reset_oe);
        $display("test reset done");
        sys_rst = 0;
        fundamental_reset_n = 1;
        wait_run(100);
        chk("master_bus_rst", 1, mb_ok);
        chk("cfg_wr", {12'h010, 32'hA5A5_0001}, wr_cap);
        chk("load_done", 1, load_done);
        chk("master_bus_slow", 1, master_bus_slow);
        chk("halt_status", 1, halt_status);
        chk("ds_reset_o", 4'hF, {ds_reset_oe, ds_reset_o});
        chk("train_quasi", 2'b10, {link_train_en, stack_quasi_rst});
        $display("test boot done");
        for (r = 0; r < 4; r++) begin
            n0 = nsr_n;
            c0 = hcpl_n;
            {us_ts1_hot_reset, us_dl_down, link_down_hot_reset_disable, hot_reset_request} = rows[r][4:1];
            tick(1);
            {us_dl_down, hot_reset_request} = 2'b00;
            tick(2);
            us_ts1_hot_reset = 0;
            tick(3);
            wait_run(40);
            chk("hot_reset", rows[r][0], nsr_n > n0);
            chk("hot_reset_cpl", rows[r][1], hcpl_n - c0);
        end
        chk("ds_hot_reset_tx", 2'h1, tx_cap);
        chk("bus_reset", 0, bus_hit);
        $display("test hot done");
        {fault, operating_mode_select, master_bus_slow_select} = {2'h1, 4'h0, 1'b0};
        warm_boot(30);
        chk("warm_reset_cpl", 1, warm_ok);
        chk("master_bus_slow", 1, master_bus_slow);
        chk("halt_after_reset", 1, halt_after_reset);
        chk("load_error_code", 8'h21, {load_error, load_done, load_error_code} & 10'hFF);
        chk("load_flags", 3, {load_error, load_done});
        chk("halt_state", 3'b111, {core_rst, stack_quasi_rst, csr_access_en});
        halt_clear = 1;
        tick(1);
        halt_clear = 0;
        wait_run(10);
        chk("halt_after_reset", 0, halt_after_reset);
        $display("test halt done");
        fault = 2'h3;
        warm_boot(30);
        chk("halt_set", 3'b101, {halt_after_reset, load_error, load_done});
        halt_clear = 1;
        tick(1);
        halt_clear = 0;
        wait_run(10);
        chk("halt_after_reset", 0, halt_after_reset);
        $display("test set halt done");
        fault = 2'h2;
        warm_boot(70);
        chk("load_error_code", 8'hFF, load_error_code);
        $display("test timeout done");
        conclude();
    end
endmodule
